// file: src/ldrt_pkg.sv
/*
 * Package for the legacy DMA register trap: I/O offsets, field positions,
 * trap kinds, reset values, the bundles carried into the trap logic and the
 * states of its fetch sequencer.
 * Assumes the host I/O cycle is presented already decoded relative to the
 * DMA base, one cycle per access.
 */
package ldrt_pkg;

    // ************************************************************
    // Offsets relative to the DMA base.
    // ************************************************************
    localparam logic [7:0] OFF_CHAN_LAST   = 8'h07; // Last address/count slot.
    localparam logic [7:0] OFF_STATUS      = 8'h08; // Shared status.
    localparam logic [7:0] OFF_SINGLE_MASK = 8'h0A; // Shared single mask.
    localparam logic [7:0] OFF_MODE        = 8'h0B; // Shared mode.
    localparam logic [7:0] OFF_CLR_BPTR    = 8'h0C; // Clear byte pointer.
    localparam logic [7:0] OFF_CLR_MASKS   = 8'h0E; // Clear all masks.
    localparam logic [7:0] OFF_ALL_MASK    = 8'h0F; // Multi-engine mask.
    localparam logic [7:0] OFF_PAGE0       = 8'h87; // Page, engine 0.
    localparam logic [7:0] OFF_PAGE1       = 8'h83; // Page, engine 1.
    localparam logic [7:0] OFF_PAGE2       = 8'h81; // Page, engine 2.
    localparam logic [7:0] OFF_PAGE3       = 8'h82; // Page, engine 3.

    // ************************************************************
    // Field positions and values.
    // ************************************************************
    localparam logic [1:0] KIND_CUSTOM_LEGACY = 2'h1; // Trap kind 01.
    localparam int         SMASK_BIT          = 2;    // Mask bit in data.
    localparam logic [7:0] TC_BITS            = 8'h0F; // Terminal counts.
    localparam logic       BPTR_RESET         = 1'b0;
    localparam logic [15:0] REG16_RESET       = 16'h0000;
    localparam logic [7:0]  REG8_RESET        = 8'h00;

    // Group trap and snoop enables.
    typedef struct packed {
        logic group1_read_trap_en;
        logic group1_write_trap_en;
        logic group1_write_snoop_en;
        logic group3_write_snoop_en;
        logic group4_read_trap_en;
        logic group4_write_snoop_en;
    } ldrt_group_ctl_t;

    // One host I/O cycle, valid for one clock.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] offset;
        logic [7:0] data;
    } ldrt_host_cyc_t;

    // Fetch sequencer states.
    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b00,
        FETCH_REQ  = 2'b01,
        FETCH_DONE = 2'b10
    } ldrt_fetch_state_t;

endpackage

// file: src/ldrt_fetch.sv
/*
 * Retry-and-fetch sequencer for the shared status and all-mask reads.
 * Assumes the bus master answers each request with a one-cycle done pulse
 * carrying the byte read from the real controller.
 */
`timescale 1ns/1ps
module ldrt_fetch
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       start_i,      // Trapped read seen, sequencer idle.
    input  wire logic [7:0] start_off_i,  // Offset of that read.
    input  wire logic       consume_i,    // Retried read served.
    input  wire logic       mst_done_i,   // Master read finished.
    output logic            mst_req,      // Master read request.
    output logic [7:0]      mst_off,      // Offset to fetch.
    output logic            busy,         // Sequence in progress.
    output logic            ready         // Fetched byte is in shadow.
);

    // ************************************************************
    // Sequencer state.
    // ************************************************************
    ldrt_pkg::ldrt_fetch_state_t state; // Current sequencer step.

    // One fetch at a time; a second offset waits for retries.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state   <= ldrt_pkg::FETCH_IDLE;
            mst_off <= 8'h00;
        end
        else if (ce_i)
        begin
            unique case (state)
                ldrt_pkg::FETCH_IDLE:
                begin
                    // A new trapped read launches the fetch.
                    if (start_i)
                    begin
                        state   <= ldrt_pkg::FETCH_REQ;
                        mst_off <= start_off_i;
                    end
                end
                ldrt_pkg::FETCH_REQ:
                begin
                    // Wait for the real controller's byte.
                    if (mst_done_i)
                    begin
                        state <= ldrt_pkg::FETCH_DONE;
                    end
                end
                ldrt_pkg::FETCH_DONE:
                begin
                    // Hold the shadow until the host retries.
                    if (consume_i)
                    begin
                        state <= ldrt_pkg::FETCH_IDLE;
                    end
                end
                default:
                begin
                    state <= ldrt_pkg::FETCH_IDLE;
                end
            endcase
        end
    end

    // Decoded views of the state.
    assign mst_req = (state == ldrt_pkg::FETCH_REQ);
    assign busy    = (state != ldrt_pkg::FETCH_IDLE);
    assign ready   = (state == ldrt_pkg::FETCH_DONE);

endmodule

// file: src/ldrt_trap.sv
/*
 * Legacy DMA register trap: emulates one engine of a legacy system DMA
 * controller by trapping and snooping host I/O cycles.
 * Assumes host I/O cycles arrive decoded against the DMA base, one clock
 * each, synchronous to mclk_i; the bus master reads the real controller.
 */
// Operation
// - Custom legacy kind makes one legacy engine.
// - Write to 0Ch clears byte pointer.
// - Accesses to offsets 0-7 flip pointer.
// - 16-bit registers, one byte per access.
// - Base writes also load current register.
// - Page byte fills upper halfword low byte.
// - Page at 87h/83h/81h/82h; address 2n, count 2n+1.
// - Only selected engine responds; others' data not stored.
// - Group-1 enables govern per-engine traps.
// - Matching mode write loads mode low byte.
// - Matching single-mask bit 2 to mask.
// - Single-mask and mode are write-snoop only.
// - Clear-all-mask snooped under group-4 snoop.
// - Status read retried, fetched, served from shadow.
// - Reading status shadow clears terminal counts.
// - Shadow writes merge external and internal status.
// - All-mask write routes engine bit to mask.
// - All-mask read retried, fetched, served from shadow.
// - All-mask register never write-trapped.
// - Page accesses do not flip pointer.
// - Clear-all-mask write clears engine mask.
// - Engine select codes 00-11 pick engine 0-3.
`timescale 1ns/1ps
module ldrt_trap
(
    input  wire logic                     mclk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    input  wire logic [1:0]               trap_kind_field_i,
    input  wire logic [1:0]               legacy_engine_select_i,
    input  wire ldrt_pkg::ldrt_group_ctl_t legacy_trap_group_control_i,
    input  wire ldrt_pkg::ldrt_host_cyc_t host_cyc_i,
    input  wire logic [7:0]               int_status_i,
    input  wire logic                     shadow_wr_i,
    input  wire logic                     mst_done_i,
    input  wire logic [7:0]               mst_rdata_i,
    output logic                          claim_o,
    output logic                          retry_o,
    output logic [7:0]                    rdata_o,
    output logic                          mst_req_o,
    output logic [7:0]                    mst_off_o,
    output logic                          byte_pointer_toggle_o,
    output logic [15:0]                   base_address_reg_o,
    output logic [15:0]                   current_address_reg_o,
    output logic [15:0]                   base_addr_upper_half_o,
    output logic [15:0]                   cur_addr_upper_half_o,
    output logic [15:0]                   base_count_reg_o,
    output logic [15:0]                   current_count_reg_o,
    output logic [7:0]                    engine_mode_reg_o,
    output logic                          request_mask_bit_o,
    output logic [7:0]                    legacy_status_shadow_o,
    output logic [7:0]                    legacy_mask_shadow_o
);

    // ************************************************************
    // Decode helpers.
    // ************************************************************

    // Page offset for an engine code.
    // page location map
    function automatic logic [7:0] page_off(input logic [1:0] eng);
        logic [7:0] r;
        unique case (eng)
            2'h0: r = ldrt_pkg::OFF_PAGE0;
            2'h1: r = ldrt_pkg::OFF_PAGE1;
            2'h2: r = ldrt_pkg::OFF_PAGE2;
            2'h3: r = ldrt_pkg::OFF_PAGE3;
        endcase
        return r;
    endfunction

    // Load one byte of a 16-bit register, chosen by the pointer.
    // byte lane select
    function automatic logic [15:0] put_byte(input logic [15:0] old,
                                             input logic [7:0]  d,
                                             input logic        hi);
        return hi ? {d, old[7:0]} : {old[15:8], d};
    endfunction

    // ************************************************************
    // Cycle classification.
    // ************************************************************
    ldrt_pkg::ldrt_group_ctl_t gc;       // Short alias for enables.
    logic       legacy_on;               // Custom legacy kind selected.
    logic       rd, wr;                  // Valid host read or write.
    logic [7:0] off;                     // Offset of the cycle.
    logic       in_chan;                 // Offsets 0 to 7.
    logic       own_addr, own_cnt;       // Selected engine's slots.
    logic       own_page;                // Selected engine's page.
    logic       own_wr;                  // Per-engine write accepted.
    logic       own_rd;                  // Per-engine read trapped.
    logic       data_match;              // Data selects our engine.
    logic       st_rd, mk_rd;            // Shared read traps.
    logic       fetch_ready, fetch_busy; // Sequencer status.
    logic       fetch_mst_req;           // Sequencer master request.
    logic [7:0] fetch_mst_off;           // Sequencer fetch offset.
    logic       shared_rd;               // Any shared read trap.
    logic       serve;                   // Shadow ready for this read.
    logic       start_fetch;             // Kick the sequencer.

    assign gc        = legacy_trap_group_control_i;
    assign legacy_on = (trap_kind_field_i == ldrt_pkg::KIND_CUSTOM_LEGACY);
    assign rd        = legacy_on && host_cyc_i.valid && !host_cyc_i.write;
    assign wr        = legacy_on && host_cyc_i.valid && host_cyc_i.write;
    assign off       = host_cyc_i.offset;
    assign in_chan   = (off <= ldrt_pkg::OFF_CHAN_LAST);
    assign own_addr  = (off == {5'h00, legacy_engine_select_i, 1'b0});
    assign own_cnt   = (off == {5'h00, legacy_engine_select_i, 1'b1});
    assign own_page  = (off == page_off(legacy_engine_select_i));
    assign own_wr    = wr && (gc.group1_write_trap_en
                              || gc.group1_write_snoop_en);
    assign own_rd    = rd && gc.group1_read_trap_en;
    assign data_match = (host_cyc_i.data[1:0] == legacy_engine_select_i);
    assign st_rd     = rd && gc.group4_read_trap_en
                       && (off == ldrt_pkg::OFF_STATUS);
    assign mk_rd     = rd && gc.group4_read_trap_en
                       && (off == ldrt_pkg::OFF_ALL_MASK);
    assign shared_rd = st_rd || mk_rd;
    assign serve     = shared_rd && fetch_ready && (fetch_mst_off == off);
    assign start_fetch = shared_rd && !fetch_busy;

    // ************************************************************
    // Retry-and-fetch sequencer.
    // ************************************************************
    ldrt_fetch u_ldrt_fetch
    (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .start_i     (start_fetch),
        .start_off_i (off),
        .consume_i   (serve),
        .mst_done_i  (mst_done_i),
        .mst_req     (fetch_mst_req),
        .mst_off     (fetch_mst_off),
        .busy        (fetch_busy),
        .ready       (fetch_ready)
    );

    // ************************************************************
    // Byte pointer toggle.
    // ************************************************************
    // The clear at 0Ch and the flip at 0-7 never meet in one cycle.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            byte_pointer_toggle_o <= ldrt_pkg::BPTR_RESET;
        end
        else if (ce_i)
        begin
            if (wr && off == ldrt_pkg::OFF_CLR_BPTR)
            begin
                byte_pointer_toggle_o <= 1'b0;
            end
            else if ((rd || wr) && in_chan)
            begin
                byte_pointer_toggle_o <= !byte_pointer_toggle_o;
            end
        end
    end

    // ************************************************************
    // Address, count and page registers.
    // ************************************************************
    // Base writes load the current copy too, so reads see fresh values.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            base_address_reg_o     <= ldrt_pkg::REG16_RESET;
            current_address_reg_o  <= ldrt_pkg::REG16_RESET;
            base_count_reg_o       <= ldrt_pkg::REG16_RESET;
            current_count_reg_o    <= ldrt_pkg::REG16_RESET;
            base_addr_upper_half_o <= ldrt_pkg::REG16_RESET;
            cur_addr_upper_half_o  <= ldrt_pkg::REG16_RESET;
        end
        else if (ce_i && own_wr)
        begin
            if (own_addr)
            begin
                base_address_reg_o <= put_byte(base_address_reg_o,
                    host_cyc_i.data, byte_pointer_toggle_o);
                current_address_reg_o <= put_byte(current_address_reg_o,
                    host_cyc_i.data, byte_pointer_toggle_o);
            end
            else if (own_cnt)
            begin
                base_count_reg_o <= put_byte(base_count_reg_o,
                    host_cyc_i.data, byte_pointer_toggle_o);
                current_count_reg_o <= put_byte(current_count_reg_o,
                    host_cyc_i.data, byte_pointer_toggle_o);
            end
            else if (own_page)
            begin
                base_addr_upper_half_o <= {8'h00, host_cyc_i.data};
                cur_addr_upper_half_o  <= {8'h00, host_cyc_i.data};
            end
        end
    end

    // ************************************************************
    // Mode and mask.
    // ************************************************************
    // Shared writes are only ever snooped; the real controller owns them.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            engine_mode_reg_o  <= ldrt_pkg::REG8_RESET;
            request_mask_bit_o <= 1'b0;
        end
        else if (ce_i && wr)
        begin
            if (gc.group3_write_snoop_en && data_match
                && off == ldrt_pkg::OFF_MODE)
            begin
                engine_mode_reg_o <= host_cyc_i.data;
            end
            else if (gc.group3_write_snoop_en && data_match
                     && off == ldrt_pkg::OFF_SINGLE_MASK)
            begin
                request_mask_bit_o <= host_cyc_i.data[ldrt_pkg::SMASK_BIT];
            end
            else if (gc.group4_write_snoop_en
                     && off == ldrt_pkg::OFF_CLR_MASKS)
            begin
                request_mask_bit_o <= 1'b0;
            end
            else if (gc.group4_write_snoop_en
                     && off == ldrt_pkg::OFF_ALL_MASK)
            begin
                request_mask_bit_o <= host_cyc_i.data[legacy_engine_select_i];
            end
        end
    end

    // ************************************************************
    // Status and mask shadows.
    // ************************************************************
    // A status read that clears TC bits must not race a fresh fetch; the
    // fetch waits in the sequencer until the retried read is served.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            legacy_status_shadow_o <= ldrt_pkg::REG8_RESET;
            legacy_mask_shadow_o   <= ldrt_pkg::REG8_RESET;
        end
        else if (ce_i)
        begin
            if (fetch_mst_req && mst_done_i)
            begin
                if (fetch_mst_off == ldrt_pkg::OFF_STATUS)
                begin
                    legacy_status_shadow_o <= mst_rdata_i;
                end
                else
                begin
                    legacy_mask_shadow_o <= mst_rdata_i;
                end
            end
            else if (shadow_wr_i)
            begin
                legacy_status_shadow_o <= legacy_status_shadow_o
                                          | int_status_i;
                legacy_mask_shadow_o   <= legacy_mask_shadow_o
                                          | {7'h00, request_mask_bit_o};
            end
            else if (serve && st_rd)
            begin
                legacy_status_shadow_o <= legacy_status_shadow_o
                                          & ~ldrt_pkg::TC_BITS;
            end
        end
    end

    // ************************************************************
    // Host answer.
    // ************************************************************
    // Registered answer; the host sees claim or retry one cycle later.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            claim_o   <= 1'b0;
            retry_o   <= 1'b0;
            rdata_o   <= 8'h00;
            mst_req_o <= 1'b0;
            mst_off_o <= 8'h00;
        end
        else if (ce_i)
        begin
            mst_req_o <= fetch_mst_req && !mst_done_i;
            mst_off_o <= fetch_mst_off;
            retry_o   <= shared_rd && !serve;
            claim_o   <= serve
                         || (own_rd && (own_addr || own_cnt || own_page))
                         || (wr && gc.group1_write_trap_en
                             && (own_addr || own_cnt || own_page));
            if (serve)
            begin
                rdata_o <= st_rd ? legacy_status_shadow_o
                                 : legacy_mask_shadow_o;
            end
            else if (own_addr)
            begin
                rdata_o <= byte_pointer_toggle_o ?
                           current_address_reg_o[15:8] :
                           current_address_reg_o[7:0];
            end
            else if (own_cnt)
            begin
                rdata_o <= byte_pointer_toggle_o ?
                           current_count_reg_o[15:8] :
                           current_count_reg_o[7:0];
            end
            else
            begin
                rdata_o <= cur_addr_upper_half_o[7:0];
            end
        end
    end

endmodule

// file: verification/ldrt_trap_monitor.sv
/* Checker for ldrt_trap: port timing of pointer, answers and fetches.
   Assumes one clock and a bind onto every ldrt_trap instance. */
`timescale 1ns/1ps
module ldrt_trap_monitor
(
    input wire logic                       mclk_i,
    input wire logic                       rst_i,
    input wire logic                       ce_i,
    input wire logic [1:0]                 trap_kind_field_i,
    input wire logic [1:0]                 legacy_engine_select_i,
    input wire ldrt_pkg::ldrt_group_ctl_t  legacy_trap_group_control_i,
    input wire ldrt_pkg::ldrt_host_cyc_t   host_cyc_i,
    input wire logic                       mst_done_i,
    input wire logic                       claim_o,
    input wire logic                       retry_o,
    input wire logic                       mst_req_o,
    input wire logic [7:0]                 mst_off_o,
    input wire logic                       byte_pointer_toggle_o,
    input wire logic [7:0]                 engine_mode_reg_o,
    input wire logic [7:0]                 legacy_status_shadow_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // A host cycle taken while the legacy mode is on.
    sequence s_take;
        ce_i && host_cyc_i.valid && trap_kind_field_i == 2'h1;
    endsequence
    // A status read that is then served from the shadow.
    sequence s_status_served;
        s_take ##0 !host_cyc_i.write && host_cyc_i.offset == 8'h08
            ##1 claim_o;
    endsequence
    a_ptr_clear_write: assert property (s_take ##0 host_cyc_i.write
        && host_cyc_i.offset == 8'h0C |=> !byte_pointer_toggle_o)
        else $error("pointer not cleared");
    a_ptr_flip_slot: assert property (s_take ##0 host_cyc_i.offset
        <= 8'h07 |=> byte_pointer_toggle_o != $past(byte_pointer_toggle_o))
        else $error("pointer not flipped");
    a_page_keeps_ptr: assert property (s_take ##0 host_cyc_i.offset[7]
        |=> $stable(byte_pointer_toggle_o))
        else $error("page access moved pointer");
    a_idle_kind_quiet: assert property (ce_i && host_cyc_i.valid &&
        trap_kind_field_i != 2'h1 |=> !claim_o && !retry_o)
        else $error("answer outside legacy mode");
    a_fetch_after_retry: assert property ($rose(mst_req_o)
        |-> $past(retry_o))
        else $error("fetch without retry");
    a_fetch_offset_ok: assert property (mst_req_o |->
        mst_off_o == 8'h08 || mst_off_o == 8'h0F)
        else $error("fetch offset wrong");
    a_fetch_ends_done: assert property (mst_req_o && mst_done_i
        |=> !mst_req_o)
        else $error("fetch request held");
    a_single_answer: assert property (claim_o |-> !retry_o)
        else $error("claim and retry together");
    a_mode_snoop_load: assert property (s_take ##0 host_cyc_i.write &&
        host_cyc_i.offset == 8'h0B &&
        legacy_trap_group_control_i.group3_write_snoop_en &&
        host_cyc_i.data[1:0] == legacy_engine_select_i
        |=> engine_mode_reg_o == $past(host_cyc_i.data))
        else $error("mode byte not loaded");
    a_status_tc_clear: assert property (s_status_served |=>
        (legacy_status_shadow_o & ldrt_pkg::TC_BITS) == 8'h00)
        else $error("terminal counts kept");
endmodule

bind ldrt_trap ldrt_trap_monitor u_ldrt_trap_monitor (.*);

// file: verification/ldrt_legacy_model.sv
/* Model of the real legacy controller answering fetch reads.
   Assumes a level request held until a one-cycle done is seen. */
`timescale 1ns/1ps
module ldrt_legacy_model
#(
    parameter logic [7:0] STATUS_VAL = 8'hA5, // Status byte to return.
    parameter logic [7:0] MASK_VAL   = 8'h0B, // Mask byte to return.
    parameter int         LAT        = 3      // Wait before answering.
)
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire logic [7:0] off_i,
    output logic            done_o,
    output logic [7:0]      rdata_o
);
    int wait_cnt; // Cycles the open request has waited.
    // Data toggles when not valid so a stale byte is never mistaken.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            done_o   <= 1'b0;
            rdata_o  <= 8'h00;
            wait_cnt <= 0;
        end
        else if (req_i && !done_o && wait_cnt == LAT)
        begin
            done_o   <= 1'b1;
            rdata_o  <= (off_i == 8'h08) ? STATUS_VAL : MASK_VAL;
            wait_cnt <= 0;
        end
        else
        begin
            done_o   <= 1'b0;
            rdata_o  <= ~rdata_o;
            wait_cnt <= (req_i && !done_o) ? wait_cnt + 1 : 0;
        end
    end
endmodule

// file: verification/ldrt_trap_test.sv
/* Self-checking bench for ldrt_trap with the legacy controller model.
   Assumes the host cycle is driven one per two clocks, 1 ns after edge. */
`timescale 1ns/1ps
module ldrt_trap_test;
    logic                      mclk_i = 1'b0;
    logic                      rst_i  = 1'b1;
    logic [1:0]                kind   = 2'h1;
    ldrt_pkg::ldrt_group_ctl_t grp    = '0;
    ldrt_pkg::ldrt_host_cyc_t  hc     = '0;
    logic                      done, req, claim, retry, ptr, msk;
    logic                      got_claim, got_retry, sw = 1'b0;
    logic [7:0]                mrd, moff, rdat, mode, sts, got_data, msh;
    logic [15:0]               ba, ca, bu, cu, bc, cc;
    int                        bad_count = 0;
    int                        tests_run = 0;
    always #5 mclk_i = ~mclk_i;
    ldrt_trap u_ldrt_trap (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
        .trap_kind_field_i(kind), .legacy_engine_select_i(2'h3),
        .legacy_trap_group_control_i(grp), .host_cyc_i(hc),
        .int_status_i(8'h40), .shadow_wr_i(sw), .mst_done_i(done),
        .mst_rdata_i(mrd), .claim_o(claim), .retry_o(retry),
        .rdata_o(rdat), .mst_req_o(req), .mst_off_o(moff),
        .byte_pointer_toggle_o(ptr), .base_address_reg_o(ba),
        .current_address_reg_o(ca), .base_addr_upper_half_o(bu),
        .cur_addr_upper_half_o(cu), .base_count_reg_o(bc),
        .current_count_reg_o(cc), .engine_mode_reg_o(mode),
        .request_mask_bit_o(msk), .legacy_status_shadow_o(sts),
        .legacy_mask_shadow_o(msh));
    ldrt_legacy_model u_ldrt_legacy_model (.mclk_i(mclk_i), .rst_i(rst_i),
        .req_i(req), .off_i(moff), .done_o(done), .rdata_o(mrd));
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One host cycle; the answer is captured 1 ns after the edge that takes it.
    task automatic cyc(input logic w, input logic [7:0] o, d);
        hc = '{1'b1, w, o, d};
        @(posedge mclk_i) #1;
        hc.valid = 1'b0;
        got_claim = claim;
        got_retry = retry;
        got_data = rdat;
        @(posedge mclk_i) #1;
    endtask
    task automatic t_regs;
        grp = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        cyc(1, 8'h06, 8'h34);
        check("claim", got_claim, 1);
        cyc(1, 8'h06, 8'h12);
        cyc(1, 8'h07, 8'h78);
        cyc(1, 8'h07, 8'h56);
        cyc(1, 8'h82, 8'hAB);
        check("ptr", ptr, 0);
        check("ba", ba, 16'h1234);
        check("ca", ca, 16'h1234);
        check("cc", cc, 16'h5678);
        check("bc", bc, 16'h5678);
        check("bu", bu, 16'h00AB);
        check("cu", cu, 16'h00AB);
        cyc(1, 8'h00, 8'h55);
        check("ptr", ptr, 1);
        check("ba", ba, 16'h1234);
        cyc(1, 8'h0C, 8'hFF);
        check("ptr", ptr, 0);
        cyc(0, 8'h06, 8'h00);
        check("rd", got_data, 16'h0034);
        kind = 2'h0;
        cyc(1, 8'h06, 8'h99);
        check("claim", got_claim, 0);
        kind = 2'h1;
        $display("t_regs done");
    endtask
    task automatic t_shared;
        grp = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        cyc(1, 8'h0B, 8'h47);
        cyc(1, 8'h0B, 8'h44);
        check("mode", mode, 8'h47);
        cyc(1, 8'h0A, 8'h07);
        check("msk", msk, 1);
        cyc(1, 8'h0E, 8'h00);
        check("msk", msk, 0);
        cyc(1, 8'h0F, 8'h08);
        check("msk", msk, 1);
        check("claim", got_claim, 0);
        $display("t_shared done");
    endtask
    // Read is retried, fetched, then served from the shadow.
    task automatic t_fetch(input logic [7:0] o, input logic [7:0] exp);
        grp = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        cyc(0, o, 8'h00);
        check("retry", got_retry, 1);
        cyc(0, o, 8'h00);
        check("retry", got_retry, 1);
        for (int i = 0; i < 20 && req !== 1'b0; i++) @(posedge mclk_i) #1;
        check("req", req, 0);
        cyc(0, o, 8'h00);
        check("claim", got_claim, 1);
        check("data", got_data, exp);
        $display("t_fetch done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        bad_count++;
        final_report;
    end
    initial
    begin
        repeat (4) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        check("ptr", ptr, 0);
        check("req", req, 0);
        t_regs;
        t_shared;
        t_fetch(8'h08, 8'hA5);
        check("sts", sts, 8'hA0);
        sw = 1'b1;
        @(posedge mclk_i) #1;
        sw = 1'b0;
        check("sts", sts, 8'hE0);
        check("msh", msh, 8'h01);
        t_fetch(8'h0F, 8'h0B);
        final_report;
    end
endmodule
